// *** verilog/dtwbsp_mem.sv ***
// Purpose: Memory end of the two-word burst DDR SRAM port
// Assumes: Link clocks and pins are sampled by sys_clk through two flip-flops
// Notes:   Storage is a plain array with no reset; contents start unknown
//
// Functional notes
// - Write words taken on K and K_n rises
// - Read words driven on C, C_n rises
// - Bus released whenever no read is driving
// - Low load strobe registers address and direction
// - Every access moves exactly two words
// - Byte selects sampled with their data word
// - Deselected bytes keep their stored value
// - Each select governs one nine-bit lane
// - One address bus serves reads and writes
// - Burst-start bit seeds one-bit burst counter
// - Address width 19 for x36, 20 for x18
// - Address ignored while port is deselected
// - Direction high reads, low writes
// - Controller supplies both output clocks together
// - Accesses start only on K rise
// - Loads not accepted on the K rise right after a load
// - Without output clocks, read data follows K
`timescale 1ns/1ps
module dtwbsp_mem #(
	parameter int DQ_W   = dtwbsp_pkg::DQ_W_X36,
	parameter int ADDR_W = dtwbsp_pkg::ADDR_W_X36
) (
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	input  wire logic  single_clk_mode,
	dtwbsp_if.mem_side bus
);
	import dtwbsp_pkg::*;

	localparam int LANES = DQ_W / LANE_W;
	localparam int SW    = 6 + ADDR_W + LANES + DQ_W;
	localparam int DEPTH = 2 ** ADDR_W;

	// Only the two documented organisations are served
	if (!((DQ_W == DQ_W_X36 && ADDR_W == ADDR_W_X36) ||
		(DQ_W == DQ_W_X18 && ADDR_W == ADDR_W_X18))) begin : g_bad_org
		$error("dtwbsp_mem: unsupported width and address combination");
	end

	// Rising edge seen on a synchronised level
	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	// Word index of a burst beat; the counter wraps in one bit
	function automatic logic [ADDR_W-1:0] burst_idx(input logic [ADDR_W-2:0] hi,
		input logic a0, input logic beat);
		return {hi, a0 ^ beat};
	endfunction

	logic [DQ_W-1:0]       mem [DEPTH];
	logic [SW-1:0]         pin_vec;
	logic [SW-1:0]         sync1_r;
	logic [SW-1:0]         sync2_r;
	logic [3:0]            clk_d_r;
	logic                  s_k;
	logic                  s_k_n;
	logic                  s_c;
	logic                  s_c_n;
	logic                  s_ld_n;
	logic                  s_rw;
	logic [ADDR_W-1:0]     s_addr;
	logic [LANES-1:0]      s_bws_n;
	logic [DQ_W-1:0]       s_dq;
	logic                  mode_s1_r;
	logic                  mode_s2_r;
	logic                  k_rise;
	logic                  kn_rise;
	logic                  out_rise;
	logic                  outn_rise;
	logic                  accept;
	logic                  skip_r;
	logic [ADDR_W-2:0]     addr_hi_r;
	logic                  a0_r;
	dtwbsp_dev_state_t     state_r;
	logic                  wr_en;
	logic [ADDR_W-1:0]     wr_idx;
	logic [DQ_W-1:0]       dq_o_r;
	logic                  dq_oe_n_r;

	// All pins gathered so they cross with one common delay
	assign pin_vec = {bus.k, bus.k_n, bus.c, bus.c_n, bus.load_strobe_n, bus.rw,
		bus.addr, bus.byte_write_select_n, bus.dq_line};

	// Two-stage synchroniser; stage one feeds stage two only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_vec;
			sync2_r <= sync1_r;
		end
	end

	assign {s_k, s_k_n, s_c, s_c_n, s_ld_n, s_rw, s_addr, s_bws_n, s_dq} = sync2_r;

	// Delayed copies of the four clocks for edge finding
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_d_r <= '0;
		end else begin
			clk_d_r <= {s_k, s_k_n, s_c, s_c_n};
		end
	end

	// Mode strap is a pin too; it crosses like the others
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_s1_r <= 1'b0;
			mode_s2_r <= 1'b0;
		end else begin
			mode_s1_r <= single_clk_mode;
			mode_s2_r <= mode_s1_r;
		end
	end

	assign k_rise  = rise(s_k, clk_d_r[3]);
	assign kn_rise = rise(s_k_n, clk_d_r[2]);

	// Single clock mode drives read data from the input pair
	assign out_rise  = mode_s2_r ? k_rise : rise(s_c, clk_d_r[1]);
	assign outn_rise = mode_s2_r ? kn_rise : rise(s_c_n, clk_d_r[0]);

	// A load counts only on a K rise that is not the second beat slot
	assign accept = k_rise && !s_ld_n && !skip_r;

	// Address and burst bit held for the second beat
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_hi_r <= '0;
			a0_r      <= 1'b0;
		end else if (accept) begin
			addr_hi_r <= s_addr[ADDR_W-1:1];
			a0_r      <= s_addr[0];
		end
	end

	// The K rise after an accepted load is busy with the burst
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_r <= 1'b0;
		end else if (k_rise) begin
			skip_r <= accept;
		end
	end

	// Burst sequencing; a new load overrides a finished read tail
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= DS_IDLE;
		end else if (accept) begin
			state_r <= (s_rw == DIR_READ) ? DS_RD0 : DS_WR1;
		end else begin
			case (state_r)
				DS_WR1: begin
					if (kn_rise) begin
						state_r <= DS_IDLE;
					end
				end
				DS_RD0: begin
					if (out_rise) begin
						state_r <= DS_RD1;
					end
				end
				DS_RD1: begin
					if (outn_rise) begin
						state_r <= DS_IDLE;
					end
				end
				default: begin
					state_r <= DS_IDLE;
				end
			endcase
		end
	end

	// First write word on the load edge, second on the next K_n rise
	assign wr_en = (accept && s_rw == DIR_WRITE) || (state_r == DS_WR1 && kn_rise);
	assign wr_idx = accept ? burst_idx(s_addr[ADDR_W-1:1], s_addr[0], 1'b0) :
		burst_idx(addr_hi_r, a0_r, 1'b1);

	// Lane-masked store; the mask is the one sampled with this word
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (!s_bws_n[i]) begin
					mem[wr_idx][i*LANE_W +: LANE_W] <= s_dq[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read drive; any other C rise lets go of the bus, other C_n rises leave it as is
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_o_r    <= '0;
			dq_oe_n_r <= 1'b1;
		end else if (out_rise) begin
			if (state_r == DS_RD0) begin
				dq_o_r    <= mem[burst_idx(addr_hi_r, a0_r, 1'b0)];
				dq_oe_n_r <= 1'b0;
			end else begin
				dq_oe_n_r <= 1'b1;
			end
		end else if (outn_rise && state_r == DS_RD1) begin
			dq_o_r    <= mem[burst_idx(addr_hi_r, a0_r, 1'b1)];
			dq_oe_n_r <= 1'b0;
		end
	end

	// Pins straight from the output flops
	assign bus.dq_mem_o    = dq_o_r;
	assign bus.dq_mem_oe_n = dq_oe_n_r;

	// A stalled output clock leaves the last word driven; the controller
	// gates C with c_enable alone and does not keep it running while reads
	// are outstanding. Single clock mode is a strap and must not change
	// while a read is in flight.

endmodule // dtwbsp_mem

// *** common/dtwbsp_pkg.sv ***
// Purpose: Shared constants and types for the two-word burst DDR SRAM port
// Assumes: One system clock for both ends; link clocks are made by the controller
// Notes:   Each link clock period spans a whole number of system clocks
package dtwbsp_pkg;

	// Organisations
	localparam int DQ_W_X36   = 36;
	localparam int ADDR_W_X36 = 19;
	localparam int DQ_W_X18   = 18;
	localparam int ADDR_W_X18 = 20;
	localparam int LANE_W     = 9;
	localparam int BURST_LEN  = 2;

	// Timing in its own unit, then in system clocks
	localparam int SYS_PERIOD_NS  = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int LINK_CYC       = LINK_PERIOD_NS / SYS_PERIOD_NS;
	localparam int HALF_CYC       = LINK_CYC / 2;
	localparam int PH_W           = $clog2(LINK_CYC);

	// Controller phases: pins change one clock before the edge they meet
	localparam int TICK_PH = LINK_CYC - 2;
	localparam int W1_PH   = HALF_CYC - 2;

	// Read capture taps, counted from the clock after the load tick
	localparam int RD_W0_TAP = 2 * LINK_CYC;
	localparam int RD_W1_TAP = RD_W0_TAP + HALF_CYC;

	// Synchroniser depth on every pin
	localparam int SYNC_STAGES = 2;

	// Direction level on the read/write pin
	localparam logic DIR_READ  = 1'b1;
	localparam logic DIR_WRITE = 1'b0;

	typedef enum logic [1:0] {
		DS_IDLE,
		DS_WR1,
		DS_RD0,
		DS_RD1
	} dtwbsp_dev_state_t;

	typedef enum logic [1:0] {
		CS_OPEN,
		CS_SKIP_WR,
		CS_SKIP_RD,
		CS_RDONLY
	} dtwbsp_ctl_state_t;

endpackage

// *** common/dtwbsp_if.sv ***
// Purpose: Pin bundle between memory controller and SRAM port
// Assumes: Output enables are active low; memory wins a contention
// Notes:   Idle bus reads as zero
`timescale 1ns/1ps
interface dtwbsp_if #(
	parameter int DQ_W   = dtwbsp_pkg::DQ_W_X36,
	parameter int ADDR_W = dtwbsp_pkg::ADDR_W_X36
);
	localparam int LANES = DQ_W / dtwbsp_pkg::LANE_W;

	logic              k;
	logic              k_n;
	logic              c;
	logic              c_n;
	logic              load_strobe_n;
	logic              rw;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0]  byte_write_select_n;
	logic [DQ_W-1:0]   dq_ctl_o;
	logic              dq_ctl_oe_n;
	logic [DQ_W-1:0]   dq_mem_o;
	logic              dq_mem_oe_n;
	logic [DQ_W-1:0]   dq_line;

	// Wire level worked out from the enables
	assign dq_line = !dq_mem_oe_n ? dq_mem_o : (!dq_ctl_oe_n ? dq_ctl_o : '0);

	modport mem_side (
		input  k, k_n, c, c_n, load_strobe_n, rw, addr, byte_write_select_n, dq_line,
		output dq_mem_o, dq_mem_oe_n
	);

	modport ctl_side (
		output k, k_n, c, c_n, load_strobe_n, rw, addr, byte_write_select_n,
		output dq_ctl_o, dq_ctl_oe_n,
		input  dq_line
	);
endinterface

// *** verilog/dtwbsp_ctrl.sv ***
// Purpose: Controller end of the two-word burst DDR SRAM port
// Assumes: Requests come from logic on sys_clk
// Notes:   Makes K, K_n, C, C_n by a divider; at most one load per two K periods
`timescale 1ns/1ps
module dtwbsp_ctrl #(
	parameter int DQ_W   = dtwbsp_pkg::DQ_W_X36,
	parameter int ADDR_W = dtwbsp_pkg::ADDR_W_X36
) (
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst_n,
	input  wire logic                                 c_enable,
	input  wire logic                                 req_valid,
	input  wire logic                                 req_write,
	input  wire logic [ADDR_W-1:0]                    req_addr,
	input  wire logic [DQ_W-1:0]                      req_wdata0,
	input  wire logic [DQ_W-1:0]                      req_wdata1,
	input  wire logic [DQ_W/dtwbsp_pkg::LANE_W-1:0]   req_bsel0_n,
	input  wire logic [DQ_W/dtwbsp_pkg::LANE_W-1:0]   req_bsel1_n,
	output logic                                      req_ack,
	output logic                                      rd_valid,
	output logic [DQ_W-1:0]                           rd_data0,
	output logic [DQ_W-1:0]                           rd_data1,
	dtwbsp_if.ctl_side                                bus
);
	import dtwbsp_pkg::*;

	localparam int LANES = DQ_W / LANE_W;

	if (LINK_CYC < 8 || LINK_CYC % 2 != 0 || DQ_W % LANE_W != 0) begin : g_bad_cfg
		$error("dtwbsp_ctrl: link period or width not servable");
	end

	logic [PH_W-1:0]       ph_r;
	logic [PH_W-1:0]       ph_nxt;
	logic                  k_nxt;
	logic                  k_r;
	logic                  kn_r;
	logic                  c_r;
	logic                  cn_r;
	logic                  tick;
	logic                  take;
	dtwbsp_ctl_state_t     slot_r;
	logic                  ld_n_r;
	logic                  rw_r;
	logic [ADDR_W-1:0]     addr_r;
	logic [LANES-1:0]      bws_n_r;
	logic [DQ_W-1:0]       dq_o_r;
	logic                  dq_oe_n_r;
	logic [DQ_W-1:0]       w1_data_r;
	logic [LANES-1:0]      w1_bws_r;
	logic                  w1_pend_r;
	logic                  ack_r;
	logic [DQ_W-1:0]       q1_r;
	logic [DQ_W-1:0]       q2_r;
	logic [RD_W1_TAP:0]    rd_pipe_r;
	logic [DQ_W-1:0]       rd0_r;
	logic [DQ_W-1:0]       rd1_r;
	logic                  rd_valid_r;

	// Divider phase; K high for the first half period
	assign ph_nxt = (ph_r == PH_W'(LINK_CYC - 1)) ? '0 : ph_r + 1'b1;
	assign k_nxt  = (ph_nxt < PH_W'(HALF_CYC));
	assign tick   = (ph_r == PH_W'(TICK_PH));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= PH_W'(LINK_CYC - 1); // No runt K pulse after release
			k_r  <= 1'b0;
			kn_r <= 1'b0;
			c_r  <= 1'b0;
			cn_r <= 1'b0;
		end else begin
			ph_r <= ph_nxt;
			k_r  <= k_nxt;
			kn_r <= ~k_nxt;
			c_r  <= c_enable & k_nxt;
			cn_r <= c_enable & ~k_nxt;
		end
	end

	// No write straight after a read, so the buses never fight
	assign take = tick && req_valid &&
		(slot_r == CS_OPEN || (slot_r == CS_RDONLY && !req_write));

	// Slot bookkeeping, advanced once per K period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_r <= CS_OPEN;
		end else if (tick) begin
			if (take) begin
				slot_r <= req_write ? CS_SKIP_WR : CS_SKIP_RD;
			end else begin
				case (slot_r)
					CS_SKIP_RD: slot_r <= CS_RDONLY;
					default:    slot_r <= CS_OPEN;
				endcase
			end
		end
	end

	// Command pins and write data; word one swaps in before K_n rises
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_n_r    <= 1'b1;
			rw_r      <= DIR_READ;
			addr_r    <= '0;
			bws_n_r   <= '1;
			dq_o_r    <= '0;
			dq_oe_n_r <= 1'b1;
			w1_data_r <= '0;
			w1_bws_r  <= '1;
			w1_pend_r <= 1'b0;
		end else if (tick) begin
			ld_n_r    <= !take;
			rw_r      <= take ? (req_write ? DIR_WRITE : DIR_READ) : DIR_READ;
			addr_r    <= take ? req_addr : addr_r;
			bws_n_r   <= (take && req_write) ? req_bsel0_n : '1;
			dq_o_r    <= req_wdata0;
			dq_oe_n_r <= !(take && req_write);
			w1_data_r <= req_wdata1;
			w1_bws_r  <= req_bsel1_n;
			w1_pend_r <= take && req_write;
		end else if (ph_r == PH_W'(W1_PH) && w1_pend_r) begin
			dq_o_r    <= w1_data_r;
			bws_n_r   <= w1_bws_r;
			w1_pend_r <= 1'b0;
		end
	end

	// Acknowledge pulse for a taken request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= take;
		end
	end

	// Read data crosses in through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q1_r <= '0;
			q2_r <= '0;
		end else begin
			q1_r <= bus.dq_line;
			q2_r <= q1_r;
		end
	end

	// Capture taps line up with the middle of each returned word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pipe_r  <= '0;
			rd0_r      <= '0;
			rd1_r      <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_pipe_r  <= {rd_pipe_r[RD_W1_TAP-1:0], take && !req_write};
			rd0_r      <= rd_pipe_r[RD_W0_TAP] ? q2_r : rd0_r;
			rd1_r      <= rd_pipe_r[RD_W1_TAP] ? q2_r : rd1_r;
			rd_valid_r <= rd_pipe_r[RD_W1_TAP];
		end
	end

	assign bus.k                   = k_r;
	assign bus.k_n                 = kn_r;
	assign bus.c                   = c_r;
	assign bus.c_n                 = cn_r;
	assign bus.load_strobe_n       = ld_n_r;
	assign bus.rw                  = rw_r;
	assign bus.addr                = addr_r;
	assign bus.byte_write_select_n = bws_n_r;
	assign bus.dq_ctl_o            = dq_o_r;
	assign bus.dq_ctl_oe_n         = dq_oe_n_r;
	assign req_ack                 = ack_r;
	assign rd_valid                = rd_valid_r;
	assign rd_data0                = rd0_r;
	assign rd_data1                = rd1_r;

endmodule // dtwbsp_ctrl

// *** test/dtwbsp_chk.sv ***
// Purpose: Pin-level checks on the link between controller and memory ends
// Assumes: One sys_clk domain; every link pin comes straight from a flop
// Notes:   Read drive window is one K period of eight clocks
`timescale 1ns/1ps
module dtwbsp_chk #(
	parameter int DQ_W   = dtwbsp_pkg::DQ_W_X36,
	parameter int ADDR_W = dtwbsp_pkg::ADDR_W_X36
) (
	input wire logic                   sys_clk,
	input wire logic                   rst_n,
	input wire logic                   k,
	input wire logic                   k_n,
	input wire logic                   c,
	input wire logic                   c_n,
	input wire logic                   load_strobe_n,
	input wire logic                   rw,
	input wire logic [ADDR_W-1:0]      addr,
	input wire logic [DQ_W/dtwbsp_pkg::LANE_W-1:0] byte_write_select_n,
	input wire logic                   dq_ctl_oe_n,
	input wire logic                   dq_mem_oe_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Load cycles split by direction
	sequence s_rd_load;
		$fell(load_strobe_n) && rw;
	endsequence
	sequence s_wr_load;
		$fell(load_strobe_n) && !rw;
	endsequence

	// Link clock shape and pairing
	a_k_square: assert property ($rose(k) |-> k[*4] ##1 (!k)[*4])
		else $error("k shape wrong");
	a_kn_inverse: assert property ($past(rst_n) |-> k_n == !k)
		else $error("k_n not inverse of k");
	a_c_tracks_k: assert property ((c || c_n) |-> c == k && c_n == k_n)
		else $error("c pair off k pair");
	// One K period per load, then a free period
	a_load_width: assert property ($fell(load_strobe_n)
		|-> (!load_strobe_n)[*8] ##1 load_strobe_n)
		else $error("load strobe width");
	a_load_gap: assert property ($rose(load_strobe_n) |-> load_strobe_n[*8])
		else $error("loads too close");
	a_load_hold: assert property (!load_strobe_n && !$past(load_strobe_n)
		|-> $stable(addr) && $stable(rw))
		else $error("address moved in load");
	// Memory drive only for reads, one bounded window
	a_rd_drive: assert property (s_rd_load |-> ##[8:20] !dq_mem_oe_n)
		else $error("read never driven");
	a_rd_window: assert property ($fell(dq_mem_oe_n)
		|-> (!dq_mem_oe_n)[*8] ##1 dq_mem_oe_n)
		else $error("read window length");
	// Drive starts twelve clocks after a read load, never from an idle bus
	a_rd_after_load: assert property ($fell(dq_mem_oe_n)
		|-> $past(rw, 12) && !$past(load_strobe_n, 12))
		else $error("drive without read load");
	a_wr_quiet: assert property (s_wr_load |-> (!dq_ctl_oe_n && dq_mem_oe_n)[*8])
		else $error("write bus ownership");
	a_no_clash: assert property (!dq_mem_oe_n |-> dq_ctl_oe_n)
		else $error("both ends drive");
	a_idle_masks: assert property (load_strobe_n && dq_ctl_oe_n |-> &byte_write_select_n)
		else $error("masks active when idle");
endmodule // dtwbsp_chk

// *** test/testbench.sv ***
// Purpose: Both ends of the burst SRAM port joined and driven from the user side
// Assumes: Inputs change on the falling edge; x36 organisation
// Notes:   Only written words are read back; the array starts unknown
`timescale 1ns/1ps
module testbench;
	import dtwbsp_pkg::*;
	localparam int DW = DQ_W_X36;
	localparam int AW = ADDR_W_X36;
	localparam int LN = DW / LANE_W;
	logic          sys_clk, rst_n, c_enable, req_valid, req_write;
	logic [AW-1:0] req_addr;
	logic [DW-1:0] req_wdata0, req_wdata1, rd_data0, rd_data1;
	logic [LN-1:0] req_bsel0_n, req_bsel1_n;
	logic          req_ack, rd_valid;
	int            num_errors, n_checks, cyc;

	dtwbsp_if #(.DQ_W(DW), .ADDR_W(AW)) bus ();
	dtwbsp_ctrl #(.DQ_W(DW), .ADDR_W(AW)) u_dtwbsp_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
		.c_enable(c_enable), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
		.req_bsel0_n(req_bsel0_n), .req_bsel1_n(req_bsel1_n), .req_ack(req_ack),
		.rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1), .bus(bus));
	// Single clock mode follows absence of the output clocks
	dtwbsp_mem #(.DQ_W(DW), .ADDR_W(AW)) u_dtwbsp_mem (.sys_clk(sys_clk), .rst_n(rst_n),
		.single_clk_mode(!c_enable), .bus(bus));
	dtwbsp_chk #(.DQ_W(DW), .ADDR_W(AW)) u_dtwbsp_chk (.sys_clk(sys_clk), .rst_n(rst_n),
		.k(bus.k), .k_n(bus.k_n), .c(bus.c), .c_n(bus.c_n),
		.load_strobe_n(bus.load_strobe_n), .rw(bus.rw), .addr(bus.addr),
		.byte_write_select_n(bus.byte_write_select_n),
		.dq_ctl_oe_n(bus.dq_ctl_oe_n), .dq_mem_oe_n(bus.dq_mem_oe_n));

	// Clock and hang guard
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			$display("[FAIL] run length expected below %0d seen %0d", 20000, cyc);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Holds the request until taken, then looks at the wire
	task automatic issue(logic wr, logic [AW-1:0] a, logic [DW-1:0] d0, logic [DW-1:0] d1,
		logic [LN-1:0] m0, logic [LN-1:0] m1);
		int n;
		n = 0;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata0 = d0;
		req_wdata1 = d1;
		req_bsel0_n = m0;
		req_bsel1_n = m1;
		do begin
			@(negedge sys_clk);
			n++;
		end while (req_ack !== 1'b1 && n < 64);
		req_valid = 1'b0;
		check("req_ack", 1, req_ack);
		check("load_strobe_n", 0, bus.load_strobe_n);
		check("rw", wr ? DIR_WRITE : DIR_READ, bus.rw);
		check("addr", a, bus.addr);
		if (wr) begin
			check("dq w0", d0, bus.dq_line);
			check("bsel w0", m0, bus.byte_write_select_n);
			repeat (4) @(negedge sys_clk);
			check("dq w1", d1, bus.dq_line);
			check("bsel w1", m1, bus.byte_write_select_n);
		end
	endtask

	task automatic wr_full(logic [AW-1:0] a, logic [DW-1:0] d0, logic [DW-1:0] d1);
		issue(1'b1, a, d0, d1, '0, '0);
	endtask

	// Waits for the burst, compares, then looks for a released bus
	task automatic rd_wait(logic [DW-1:0] e0, logic [DW-1:0] e1);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 64) begin
			@(negedge sys_clk);
			n++;
		end
		check("rd_valid", 1, rd_valid);
		check("rd_data0", e0, rd_data0);
		check("rd_data1", e1, rd_data1);
		@(negedge sys_clk);
		check("mem oe_n", 1, bus.dq_mem_oe_n);
		check("idle line", 0, bus.dq_line);
	endtask

	task automatic rd_chk(logic [AW-1:0] a, logic [DW-1:0] e0, logic [DW-1:0] e1);
		issue(1'b0, a, '0, '0, '1, '1);
		rd_wait(e0, e1);
	endtask

	// Plain burst, then entered at the odd word
	task automatic s_burst();
		wr_full(19'h0_0010, 36'h1_1111_1111, 36'h2_2222_2222);
		rd_chk(19'h0_0010, 36'h1_1111_1111, 36'h2_2222_2222);
		rd_chk(19'h0_0011, 36'h2_2222_2222, 36'h1_1111_1111);
		wr_full(19'h0_0021, 36'h3_3333_3333, 36'h4_4444_4444);
		rd_chk(19'h0_0020, 36'h4_4444_4444, 36'h3_3333_3333);
	endtask

	// One lane per word at a time, separate masks for the two words
	task automatic s_masks();
		logic [DW-1:0] e0, e1;
		int            j;
		e0 = '0;
		e1 = '0;
		wr_full(19'h0_0030, '0, '0);
		for (int i = 0; i < LN; i++) begin
			j = (i + 1) % LN;
			e0 |= 36'h0_0000_01ff << (LANE_W * i);
			e1 |= 36'h0_0000_01ff << (LANE_W * j);
			issue(1'b1, 19'h0_0030, '1, '1, ~(4'h1 << i), ~(4'h1 << j));
			rd_chk(19'h0_0030, e0, e1);
		end
	endtask

	// Top address bit, then two reads two K periods apart, with one skipped slot between
	task automatic s_b2b();
		wr_full(19'h4_0010, 36'h5_5555_5555, 36'h6_6666_6666);
		issue(1'b0, 19'h4_0010, '0, '0, '1, '1);
		issue(1'b0, 19'h0_0010, '0, '0, '1, '1);
		rd_wait(36'h5_5555_5555, 36'h6_6666_6666);
		rd_wait(36'h1_1111_1111, 36'h2_2222_2222);
	endtask

	// Output clocks withheld: read data timed by the input pair
	task automatic s_single();
		@(negedge sys_clk);
		check("c follows k", bus.k, bus.c);
		c_enable = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("c held", 0, bus.c);
		check("c_n held", 0, bus.c_n);
		rd_chk(19'h4_0011, 36'h6_6666_6666, 36'h5_5555_5555);
		c_enable = 1'b1;
	endtask

	// Reset, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		c_enable = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata0 = '0;
		req_wdata1 = '0;
		req_bsel0_n = '1;
		req_bsel1_n = '1;
		num_errors = 0;
		n_checks = 0;
		cyc = 0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		s_burst();
		s_masks();
		s_b2b();
		s_single();
		end_sim();
	end
endmodule // testbench
